//--- sar_ctrl_pkg.sv
/*
  Package for the successive-approximation conversion control:
  bit counts, timing constants, state codes and bus carriers.
  Assumes a single 10 MHz system clock.
*/
package sar_ctrl_pkg;
  localparam int RESULT_BITS = 10;
  localparam int BUS_BITS = 8;
  localparam int STEP_CLKS = 8;
  localparam int STEP_W = 3;
  localparam int NUM_STEPS = 10;
  localparam int CONV_CLKS = 80;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ONESHOT_NS = 400;
  // longest time, rounded down, at least one cycle
  localparam int ONESHOT_CLKS_RAW = ONESHOT_NS / CLK_PERIOD_NS;
  localparam int ONESHOT_CLKS = (ONESHOT_CLKS_RAW < 1) ? 1 : ONESHOT_CLKS_RAW;
  localparam int ONESHOT_W = 3;
  localparam logic [RESULT_BITS-1:0] RESULT_RST = 10'h000;
  localparam logic [STEP_W-1:0] STEP_LAST = 3'h7;
  localparam logic [5:0] LOW_BYTE_PAD = 6'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic select_n;
    logic start_n;
    logic read_n;
  } host_strobes_t;

  typedef struct packed {
    logic [BUS_BITS-1:0] data;
    logic oe;
  } data_bus_t;
endpackage

//--- done_oneshot.sv
/*
  One-shot that stretches a single-cycle trigger into a pulse of
  ONESHOT_CLKS cycles. Assumes synchronous trigger and released reset.
*/
`timescale 1ns/10ps
`default_nettype none
module done_oneshot
  import sar_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic trig_i,
  output logic pulse_o
);
  logic [ONESHOT_W-1:0] count;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
    end else if (trig_i) begin
      count <= ONESHOT_W'(ONESHOT_CLKS);
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign pulse_o = (count != '0);
endmodule
`default_nettype wire

//--- sar_conv_ctrl.sv
/*
  Conversion control of a 10-bit successive-approximation converter
  with an 8-bit strobe interface. Assumes host strobes are asynchronous
  pins, comparator output is a pin, and the data bus is resolved outside.
*/
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RULE_01 - msb first, ten comparisons, eighty clocks in total
// RULE_02 - result lands in output latch before done goes low
// RULE_03 - free running: done wired to start with select low
// RULE_04 - host gives one start pulse after power-up
// RULE_05 - new start aborts a running conversion
// RULE_06 - start falling clears result and shift stages
// RULE_07 - select and start low hold reset, no progress
// RULE_08 - conversion begins 1 to 8 clocks after strobe release; code always waits 8 clocks after the synchronised release
// RULE_09 - start flop clears step counter, done, loads marker one
// RULE_10 - gated clear drops start flop only once condition gone
// RULE_11 - marker leaving copies result, transfer fall fires one-shot
// RULE_12 - done low for the one-shot length even while reading
// RULE_13 - select and read low clear done and drive bus
// RULE_14 - two reads: bits 9..2, then bits 1..0 padded
// RULE_15 - each step sets trial bit, keeps it if comparator high
module sar_conv_ctrl
  import sar_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic select_n_i,
  input wire logic start_n_i,
  input wire logic read_n_i,
  input wire logic comp_high_i,
  output logic conv_done_n_o,
  output logic [BUS_BITS-1:0] data_o,
  output logic data_oe_o,
  output logic [RESULT_BITS-1:0] trial_o
);
  logic rst_m, rst_s;
  host_strobes_t strb_m, strb_s, strb_d;
  logic comp_m, comp_s;
  conv_state_t state, next_state;
  logic start_flop;
  logic [RESULT_BITS-1:0] marker;
  logic [RESULT_BITS-1:0] sar;
  logic [RESULT_BITS-1:0] out_latch;
  logic [STEP_W-1:0] step;
  logic result_transfer, result_transfer_d;
  logic done_flag;
  logic byte_sel;
  logic first_stage_flop;
  logic oneshot;
  data_bus_t bus;
  logic [6:0] conv_cycles;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_s) begin
    if (!rst_s) begin
      strb_m <= 3'b111;
      strb_s <= 3'b111;
      strb_d <= 3'b111;
      comp_m <= 1'b0;
      comp_s <= 1'b0;
    end else begin
      strb_m <= '{select_n: select_n_i, start_n: start_n_i, read_n: read_n_i};
      strb_s <= strb_m;
      strb_d <= strb_s;
      comp_m <= comp_high_i;
      comp_s <= comp_m;
    end
  end

  wire start_req = !strb_s.select_n && !strb_s.start_n;
  wire start_fall = start_req && !(!strb_d.select_n && !strb_d.start_n);
  wire read_req = !strb_s.select_n && !strb_s.read_n;
  wire read_rise = !read_req && !strb_d.select_n && !strb_d.read_n;
  // RULE_10 gated start clear
  wire start_clear_gate = first_stage_flop && (step == STEP_LAST) && !start_req;
  wire step_end = (step == STEP_LAST);
  // RULE_05 abort wins over completion
  wire marker_out = (state == ST_CONV) && step_end && marker[0] && !start_req;
  wire result_transfer_fall = result_transfer_d && !result_transfer;

  assign first_stage_flop = marker[RESULT_BITS-1];

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (start_req) next_state = ST_HOLD;
      ST_HOLD: if (start_clear_gate) next_state = ST_CONV;
      ST_CONV: begin
        if (start_req) next_state = ST_HOLD;
        else if (marker_out) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_s) begin
    if (!rst_s) begin
      state <= ST_IDLE;
      start_flop <= 1'b0;
      step <= '0;
      marker <= '0;
      sar <= RESULT_RST;
    end else begin
      state <= next_state;
      // RULE_05 RULE_06 RULE_07 abort and hold
      if (start_req) begin
        start_flop <= 1'b1;
        step <= '0;
        sar <= RESULT_RST;
        // RULE_09 load marker one
        marker <= {1'b1, {(RESULT_BITS-1){1'b0}}};
      end else if (state == ST_HOLD) begin
        // RULE_08 phase wait of exactly 8 clocks
        step <= step + 1'b1;
        if (start_clear_gate) begin
          start_flop <= 1'b0;
          sar <= {1'b1, {(RESULT_BITS-1){1'b0}}};
        end
      end else if (state == ST_CONV) begin
        // RULE_01 RULE_15 eight clocks per trial bit
        step <= step + 1'b1;
        if (step_end) begin
          marker <= marker >> 1;
          sar <= (sar & ~marker) | (comp_s ? marker : '0) | (marker >> 1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_s) begin
    if (!rst_s) begin
      result_transfer <= 1'b0;
      result_transfer_d <= 1'b0;
      out_latch <= RESULT_RST;
    end else begin
      result_transfer_d <= result_transfer;
      result_transfer <= marker_out;
      // RULE_02 RULE_11 copy result on transfer
      if (marker_out) begin
        out_latch <= (sar & ~marker) | (comp_s ? marker : '0);
      end
    end
  end

  // RULE_11 RULE_12 one-shot on transfer fall
  done_oneshot u_oneshot (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_s),
    .trig_i(result_transfer_fall),
    .pulse_o(oneshot)
  );

  always_ff @(posedge sys_clk_i or negedge rst_s) begin
    if (!rst_s) begin
      done_flag <= 1'b0;
      byte_sel <= 1'b0;
    end else begin
      // RULE_12 RULE_13 set wins over read clear
      if (oneshot) begin
        done_flag <= 1'b1;
      end else if (read_req || start_flop) begin
        done_flag <= 1'b0;
      end
      // RULE_14 byte order toggles per read
      if (marker_out || start_req) begin
        byte_sel <= 1'b0;
      end else if (read_rise) begin
        byte_sel <= ~byte_sel;
      end
    end
  end

  // RULE_14 byte format
  wire [BUS_BITS-1:0] byte_out = byte_sel ? {out_latch[1:0], LOW_BYTE_PAD} : out_latch[RESULT_BITS-1:2];
  assign bus = '{data: byte_out, oe: read_req};
  assign data_o = bus.data;
  assign data_oe_o = bus.oe;
  assign conv_done_n_o = ~done_flag;
  assign trial_o = sar;

  property p_hold_no_progress;
    @(posedge sys_clk_i) disable iff (!rst_s)
      start_req |=> (state == ST_HOLD) && (marker == 10'h200);
  endproperty
  a_hold_no_progress: assert property (p_hold_no_progress) else $error("start held but progress made"); // RULE_07

  property p_start_within_8;
    @(posedge sys_clk_i) disable iff (!rst_s)
      (state == ST_HOLD && !start_req) |-> ##[1:8] (state == ST_CONV || start_req);
  endproperty
  a_start_within_8: assert property (p_start_within_8) else $error("conversion did not start in 8 clocks"); // RULE_08

  // RULE_01 cycles spent converting
  always_ff @(posedge sys_clk_i or negedge rst_s) begin
    if (!rst_s) begin
      conv_cycles <= 7'h00;
    end else if (state == ST_CONV) begin
      conv_cycles <= conv_cycles + 7'h01;
    end else begin
      conv_cycles <= 7'h00;
    end
  end

  property p_conv_length;
    @(posedge sys_clk_i) disable iff (!rst_s)
      marker_out |-> conv_cycles == 7'(CONV_CLKS - 1);
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("conversion ended early"); // RULE_01

  property p_abort;
    @(posedge sys_clk_i) disable iff (!rst_s)
      (state == ST_CONV && start_req) |=> state == ST_HOLD;
  endproperty
  a_abort: assert property (p_abort) else $error("start did not abort"); // RULE_05

  property p_clear_on_start;
    @(posedge sys_clk_i) disable iff (!rst_s)
      start_fall |=> sar == 10'h000 && step == 3'h0;
  endproperty
  a_clear_on_start: assert property (p_clear_on_start) else $error("start did not clear search"); // RULE_06

  property p_latch_before_done;
    @(posedge sys_clk_i) disable iff (!rst_s)
      marker_out |=> (out_latch == trial_o) && conv_done_n_o ##2 conv_done_n_o ##1 !conv_done_n_o;
  endproperty
  a_latch_before_done: assert property (p_latch_before_done) else $error("done not after latch"); // RULE_02

  property p_done_pulse;
    @(posedge sys_clk_i) disable iff (!rst_s)
      $rose(oneshot) |=> (!conv_done_n_o) [*4];
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse too short"); // RULE_12

  property p_read_clears;
    @(posedge sys_clk_i) disable iff (!rst_s)
      (read_req && !oneshot) |=> conv_done_n_o && data_oe_o == read_req;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear done"); // RULE_13

  property p_second_byte;
    @(posedge sys_clk_i) disable iff (!rst_s)
      byte_sel |-> data_o[5:0] == 6'h00;
  endproperty
  a_second_byte: assert property (p_second_byte) else $error("low byte padding wrong"); // RULE_14

  c_conv: cover property (@(posedge sys_clk_i) disable iff (!rst_s) marker_out);
  c_abort: cover property (@(posedge sys_clk_i) disable iff (!rst_s) state == ST_CONV && start_req);
  c_read_two: cover property (@(posedge sys_clk_i) disable iff (!rst_s) read_rise && byte_sel);
endmodule
`default_nettype wire

//--- sar_host_model.sv
/*
  Host side of the converter: strobe driver and comparator.
  Assumes a running clock; the bench calls the tasks.
*/
`timescale 1ns/10ps
`default_nettype none
module sar_host_model
  import sar_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic [RESULT_BITS-1:0] trial_i,
  input wire logic conv_done_n_i,
  input wire logic [BUS_BITS-1:0] data_i,
  input wire logic data_oe_i,
  output var host_strobes_t strb_o,
  output var logic comp_high_o
);
  logic [RESULT_BITS-1:0] vin = 10'h000;
  logic free_run = 1'b0;
  host_strobes_t drv = 3'b111;
  assign comp_high_o = vin > trial_i;
  always_comb begin
    strb_o = drv;
    strb_o.select_n = drv.select_n & ~free_run;
    strb_o.start_n = drv.start_n & (free_run ? conv_done_n_i : 1'b1);
  end
  task automatic start_pulse(input logic [RESULT_BITS-1:0] v, input int w);
    @(negedge clk_i);
    vin = v;
    drv.select_n = 1'b0;
    drv.start_n = 1'b0;
    repeat (w) @(negedge clk_i);
    drv.start_n = 1'b1;
    drv.select_n = drv.read_n;
  endtask
  task automatic read_byte(output logic [BUS_BITS-1:0] b, output bit ok);
    int n;
    n = 0;
    @(negedge clk_i);
    drv.select_n = 1'b0;
    drv.read_n = 1'b0;
    do begin
      @(negedge clk_i);
      n++;
    end while (data_oe_i !== 1'b1 && n < 8);
    ok = data_oe_i === 1'b1;
    b = data_i;
    @(negedge clk_i);
    drv = 3'b111;
    repeat (3) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
/*
  Self-checking bench of the conversion control.
  Assumes the host model on the strobes and a 10 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sar_ctrl_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  host_strobes_t strb;
  logic comp_high;
  logic conv_done_n;
  logic data_oe;
  logic [BUS_BITS-1:0] data;
  logic [RESULT_BITS-1:0] trial;
  int bad_count = 0;
  int samples_checked = 0;
  int seed = 32'hf7c3;
  always #50 sys_clk = ~sys_clk;
  sar_conv_ctrl sar_conv_ctrl_i(.sys_clk_i(sys_clk), .rst_b_i(rst_b), .select_n_i(strb.select_n),
    .start_n_i(strb.start_n), .read_n_i(strb.read_n), .comp_high_i(comp_high), .conv_done_n_o(conv_done_n),
    .data_o(data), .data_oe_o(data_oe), .trial_o(trial));
  sar_host_model sar_host_model_i(.clk_i(sys_clk), .trial_i(trial), .conv_done_n_i(conv_done_n),
    .data_i(data), .data_oe_i(data_oe), .strb_o(strb), .comp_high_o(comp_high));
  task automatic check(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  function automatic logic [RESULT_BITS-1:0] sar_expect(input logic [RESULT_BITS-1:0] v);
    logic [RESULT_BITS-1:0] r;
    logic [RESULT_BITS-1:0] t;
    r = 10'h000;
    for (int b = RESULT_BITS - 1; b >= 0; b--) begin
      t = r | (10'h001 << b);
      if (v > t) r = t;
    end
    return r;
  endfunction
  task automatic wait_done(output int n, output logic [RESULT_BITS-1:0] first);
    bit seen_zero;
    n = 0;
    seen_zero = 1'b0;
    first = 10'h000;
    while (conv_done_n !== 1'b0 && n < 200) begin
      @(negedge sys_clk);
      n++;
      if (trial === 10'h000) begin
        seen_zero = 1'b1;
      end else if (seen_zero && first === 10'h000) begin
        first = trial;
      end
    end
  endtask
  task automatic convert(input logic [RESULT_BITS-1:0] v, input int w);
    int n;
    logic [RESULT_BITS-1:0] first;
    logic [RESULT_BITS-1:0] exp;
    logic [BUS_BITS-1:0] b;
    bit ok;
    exp = sar_expect(v);
    sar_host_model_i.start_pulse(v, w);
    wait_done(n, first);
    check(n >= 81 && n <= 94, "conversion time");
    check(first === 10'h200, "first trial not msb");
    sar_host_model_i.read_byte(b, ok);
    check(ok && b === exp[9:2], "high byte");
    check(conv_done_n === 1'b1, "done not cleared by read");
    sar_host_model_i.read_byte(b, ok);
    check(ok && b === {exp[1:0], 6'h00}, "low byte");
  endtask
  task automatic close_out();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
  initial begin
    int r;
    int m;
    logic [RESULT_BITS-1:0] first;
    logic prev;
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    convert(10'h3ff, 1);
    convert(10'h000, 30);
    convert(10'h001, 2);
    convert(10'h200, 8);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      convert(r[9:0], 1 + (r[15:12] % 12));
    end
    // abort a conversion in mid-run
    sar_host_model_i.start_pulse(10'h2aa, 2);
    repeat (40) @(negedge sys_clk);
    convert(10'h155, 4);
    // read held low all through the conversion
    sar_host_model_i.drv.read_n = 1'b0;
    sar_host_model_i.start_pulse(10'h0f0, 3);
    wait_done(m, first);
    m = 0;
    while (conv_done_n === 1'b0 && m < 20) begin
      @(negedge sys_clk);
      m++;
    end
    check(m >= ONESHOT_CLKS && m <= ONESHOT_CLKS + 3, "done pulse length with read held");
    @(negedge sys_clk);
    sar_host_model_i.drv = 3'b111;
    // free running after one external start
    sar_host_model_i.start_pulse(10'h123, 2);
    sar_host_model_i.free_run = 1'b1;
    m = 0;
    prev = conv_done_n;
    repeat (400) begin
      @(negedge sys_clk);
      if (prev === 1'b1 && conv_done_n === 1'b0) m++;
      prev = conv_done_n;
    end
    check(m >= 3 && m <= 5, "free running rate");
    close_out();
  end
endmodule
`default_nettype wire
